// ---- testbench.sv ----
// testbench: bus tasks and register scenarios for the receive flow block
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  import urx_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn, ce, hsel, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hreadyout, hresp, rts_n, tx_hold, send_xoff, send_xon, irq, irtx, rx_serial;
  logic        rx_valid, tick16, cts_n, tx_serial, tx_bit_start, rx_pin;
  logic [7:0]  rx_char, v;
  logic [2:0]  rx_err;
  int          bad_count = 0;
  int          total_checks = 0;
  int          xon_seen = 0;
  int          ir_seen = 0;
  int          n;
  always #10 hclk = ~hclk;
  urx_flow dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_valid, .rx_char, .rx_err,
    .tick16, .cts_n, .rts_n, .tx_hold, .send_xoff, .send_xon, .irq, .tx_serial,
    .tx_bit_start, .irtx, .rx_pin, .rx_serial);
  urx_remote rem_u (.hclk, .tx_hold, .rx_valid, .rx_char, .rx_err, .tick16, .cts_n,
    .tx_serial, .tx_bit_start, .rx_pin);
  always @(posedge hclk)
  begin
    if (send_xon === 1'b1) xon_seen++;
    if (irtx === 1'b1) ir_seen++;
  end
  // ----------------------------------------
  // bus access, zero wait slave but waits anyway
  // ----------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= 32'(a);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= 32'(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(a, 1'b0, 8'h00, q);
  endtask : rd
  task automatic wt_hold(input logic want);
    for (int k = 0; k < 900 && tx_hold !== want; k++) @(posedge hclk);
    `CHK(tx_hold, want)
  endtask : wt_hold
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #400_000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    {hresetn, ce, hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    ce <= 1'b1;
    for (int a = 0; a < 4; a++)
    begin
      rd(A_XON1 + 8'(4 * a), v);
      `CHK(v, RST_REG)
    end
    wr(8'h40, 8'hFF);
    rd(8'h40, v);
    `CHK(v, 8'h00)
    wr(A_XON1, 8'hA5);
    rd(A_XON1, v);
    `CHK(v, 8'hA5)
    `CHK(rts_n, 1'b1)
    // level index 1: trigger 16, upper 24, lower 8
    wr(A_FCR, 8'h41);
    wr(A_EFR, 8'h50);
    wr(A_IER, 8'h41);
    wr(A_MCR, 8'h02);
    @(posedge hclk);
    `CHK(rts_n, 1'b0)
    for (int i = 0; i < 129; i++)
    begin
      rem_u.put(8'(i), 3'(i));
      repeat (2) @(posedge hclk);
      if (i == 14) `CHK({irq, rts_n}, 2'b00)
      if (i == 22) `CHK({irq, rts_n}, 2'b10)
      if (i == 23) `CHK(rts_n, 1'b1)
    end
    rd(A_FLVL, v);
    `CHK(v, FULL_LVL)
    rd(A_ISR, v);
    `CHK(v[5], 1'b1)
    rd(A_LSR, v);
    `CHK(v[4:2], 3'h0)
    for (int i = 0; i < 128; i++)
    begin
      rd(A_RHR, v);
      `CHK(v, 8'(i))
      rd(A_LSR, v);
      if (i < 127) `CHK({v[4:2], v[0]}, {3'(i + 1), 1'b1})
      if (i == 118) `CHK(rts_n, 1'b1)
      if (i == 119) `CHK(rts_n, 1'b0)
    end
    wr(A_FCR, 8'h01);
    wr(A_EFR, 8'h12);
    wr(A_IER, 8'h20);
    wr(A_XOFF1, 8'h13);
    wr(A_XON1, 8'h11);
    wr(A_LCR, 8'h00);
    rem_u.put(8'hF3, 3'h0);
    wt_hold(1'b1);
    rd(A_FLVL, v);
    `CHK({v, irq}, {8'h00, 1'b1})
    rem_u.put(8'hF1, 3'h0);
    wt_hold(1'b0);
    `CHK(irq, 1'b0)
    wr(A_LCR, 8'h03);
    rem_u.put(8'hF3, 3'h0);
    wr(A_XOFF2, 8'h55);
    wr(A_EFR, 8'h32);
    rem_u.put(8'h55, 3'h0);
    rd(A_FLVL, v);
    `CHK({v, tx_hold}, {8'h02, 1'b0})
    rd(A_ISR, v);
    `CHK(v[4], 1'b1)
    rd(A_RHR, v);
    rd(A_RHR, v);
    `CHK(v, 8'h55)
    // double characters: only the second of each pair is dropped
    wr(A_EFR, 8'h13);
    rem_u.put(8'h13, 3'h0);
    rem_u.put(8'h55, 3'h0);
    wt_hold(1'b1);
    rem_u.put(8'h11, 3'h0);
    rem_u.put(8'h00, 3'h0);
    wt_hold(1'b0);
    rd(A_FLVL, v);
    `CHK(v, 8'h02)
    rd(A_RHR, v);
    `CHK(v, 8'h13)
    rd(A_RHR, v);
    `CHK(v, 8'h11)
    // eight bit words: 32 * (7 + 3) ticks, one tick per two clocks
    wr(A_EFR, 8'h08);
    for (int i = 0; i < 8; i++) rem_u.put(8'(i), 3'h0);
    n = 0;
    while (send_xoff !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
    `CHK(1'(n >= 632 && n <= 648), 1'b1)
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7) `CHK(xon_seen, 0)
      rd(A_RHR, v);
    end
    repeat (4) @(posedge hclk);
    `CHK(xon_seen, 1)
    wr(A_EFR, 8'h90);
    wr(A_IER, 8'h80);
    rem_u.cts_n <= 1'b1;
    wt_hold(1'b1);
    @(posedge hclk);
    `CHK(irq, 1'b1)
    rd(A_ISR, v);
    `CHK(v[5], 1'b1)
    rem_u.cts_n <= 1'b0;
    wt_hold(1'b0);
    wr(A_EFR, 8'h00);
    wr(A_MCR, 8'h40);
    repeat (700) @(posedge hclk);
    `CHK(1'(ir_seen > 0), 1'b1)
    `CHK(rx_serial, 1'b1)
    for (int p = 0; p < 2; p++)
    begin
      rem_u.rx_pin <= 1'(p == 0);
      repeat (4) @(posedge hclk);
      rem_u.rx_pin <= 1'(p == 1);
      repeat (8) @(posedge hclk);
      `CHK(rx_serial, 1'b0)
      repeat (80) @(posedge hclk);
      `CHK(rx_serial, 1'b1)
      wr(A_FEATURE_CONTROL_REGISTER, 8'h04);
    end
    // programmable table: upper 4 + 2, lower 4 - 2
    wr(A_TRIG, 8'h04);
    wr(A_HYST, 8'h02);
    wr(A_FCR, 8'h21);
    wr(A_EFR, 8'h40);
    wr(A_MCR, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      rem_u.put(8'(i), 3'h0);
      repeat (2) @(posedge hclk);
      `CHK(rts_n, 1'(i == 5))
    end
    for (int i = 0; i < 3; i++) rd(A_RHR, v);
    repeat (2) @(posedge hclk);
    `CHK(rts_n, 1'b1)
    rd(A_RHR, v);
    repeat (2) @(posedge hclk);
    `CHK(rts_n, 1'b0)
    report_and_stop();
  end
endmodule : testbench

// ---- urx_fifo.sv ----
// receive fifo with error tags per entry
`timescale 1ns/100ps
module urx_fifo
  import urx_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  input  wire logic                     push,
  input  wire logic [urx_pkg::EW-1:0]   din,
  input  wire logic                     pop,
  output logic      [urx_pkg::EW-1:0]   dout,
  output logic      [7:0]               count
);
  import urx_pkg::*;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [7:0]    cnt;
  } urx_fifo_type;

  urx_fifo_type     s_r;
  urx_fifo_type     s_nxt;
  logic [EW-1:0]    mem [DEPTH];
  logic             do_push;
  logic             do_pop;

  assign do_push = ce & push & (s_r.cnt != FULL_LVL);
  assign do_pop  = ce & pop & (s_r.cnt != 8'h00);
  assign dout    = mem[s_r.rp];
  assign count   = s_r.cnt;

  always_comb
  begin
    s_nxt = s_r;
    if (do_push)
    begin
      s_nxt.wp = s_r.wp + 7'h01;
    end
    if (do_pop)
    begin
      s_nxt.rp = s_r.rp + 7'h01;
    end
    s_nxt.cnt = s_r.cnt + {7'h00, do_push} - {7'h00, do_pop};
  end

  // memory kept out of reset so it maps to plain ram
  always_ff @(posedge hclk)
  begin
    if (do_push)
    begin
      mem[s_r.wp] <= din;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end
endmodule : urx_fifo

// ---- urx_flow.sv ----
// receive path, hardware and software flow control, infrared coding
// ---------------------------------------------------------------
// Operation
// - fifo holds 128 entries of 11 bits
// - holding read loads next, status tags follow
// - fifo enabled: holding shows oldest character
// - auto rts enabled, started by rts control
// - rts rising edge raises rts/cts status
// - interrupt at trigger, rts off at upper
// - rts back on at lower limit
// - table limits are neighbouring trigger levels, full and empty at the ends
// - auto cts gates the transmitter
// - cts going high raises rts/cts status
// - transmitter halts after stop, resumes on low
// - xoff match halts transmission after character
// - xoff match sets flag and interrupt
// - xon match resumes and clears flag
// - reset clears xon and xoff registers
// - matched flow characters are not stored; in double mode only the second of each pair is dropped
// - xoff sent two characters after trigger
// - xon sent at or below lower level
// - special character stored and flagged
// - compare only selected word length bits
// - ir encoder: 3/16 high pulse per zero
// - ir receive idles low, optional inversion
// ---------------------------------------------------------------
`timescale 1ns/100ps
module urx_flow
  import urx_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_char,
  input  wire logic [2:0]   rx_err,
  input  wire logic         tick16,
  input  wire logic         cts_n,
  output logic              rts_n,
  output logic              tx_hold,
  output logic              send_xoff,
  output logic              send_xon,
  output logic              irq,
  input  wire logic         tx_serial,
  input  wire logic         tx_bit_start,
  output logic              irtx,
  input  wire logic         rx_pin,
  output logic              rx_serial
);
  import urx_pkg::*;

  typedef struct packed {
    logic [7:0]  interrupt_enable_register;
    logic [7:0]  fifo_control_register;
    logic [7:0]  line_control_register;
    logic [7:0]  modem_control_register;
    logic [7:0]  enhanced_feature_register;
    logic [7:0]  feature_control_register;
    logic [7:0]  xon1;
    logic [7:0]  xon2;
    logic [7:0]  xoff1;
    logic [7:0]  xoff2;
    logic [7:0]  trig;
    logic [7:0]  hyst;
    logic [5:4]  interrupt_status_register;
    logic        rts_off;
    logic        sw_hold;
    logic        xoff_sent;
    logic        xt_on;
    logic [9:0]  xt;
    logic        above;
    logic        xon1_seen;
    logic        xoff1_seen;
    logic        rts_q;
    logic        cts_q;
    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic [31:0] rdata;
    logic        send_xoff;
    logic        send_xon;
    logic [3:0]  tx_ph;
    logic [3:0]  rx_str;
    logic        irtx;
    logic        rxs;
  } urx_state_type;

  urx_state_type    s_r;
  urx_state_type    s_nxt;
  logic [EW-1:0]    head;
  logic [7:0]       cnt;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------
  // receive fifo
  // ---------------------------------------------------------------
  urx_fifo u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .push    (push),
    .din     ({rx_err, rx_char}),
    .pop     (pop),
    .dout    (head),
    .count   (cnt)
  );

  function automatic logic [7:0] lvl_of(input logic [1:0] i);
    case (i)
      2'd0:    lvl_of = TRIG_B0;
      2'd1:    lvl_of = TRIG_B1;
      2'd2:    lvl_of = TRIG_B2;
      default: lvl_of = TRIG_B3;
    endcase
  endfunction : lvl_of

  logic [7:0]  mask;
  logic [7:0]  c;
  logic [7:0]  trig_lvl;
  logic [7:0]  upper;
  logic [7:0]  lower;
  logic [1:0]  idx;
  logic        tab_d;
  logic        is_xoff;
  logic        is_xon;
  logic        special;
  logic        acc;
  logic [7:0]  a;
  logic [7:0]  rd;
  logic        rts_now;
  logic        rin;
  logic [9:0]  bits;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.send_xoff = 1'b0;
    s_nxt.send_xon  = 1'b0;
    // -------------------------------------------------------------
    // trigger and hysteresis limits
    // -------------------------------------------------------------
    idx      = s_r.fifo_control_register[7:6];
    tab_d    = s_r.fifo_control_register[FCR_TABD];
    trig_lvl = tab_d ? s_r.trig : lvl_of(idx);
    if (tab_d)
    begin
      upper = s_r.trig + s_r.hyst;
      lower = (s_r.trig > s_r.hyst) ? s_r.trig - s_r.hyst : 8'h00;
    end
    else
    begin
      upper = (idx == 2'd3) ? FULL_LVL : lvl_of(idx + 2'd1);
      lower = (idx == 2'd0) ? 8'h00 : lvl_of(idx - 2'd1);
    end
    // -------------------------------------------------------------
    // character compare
    // -------------------------------------------------------------
    case (s_r.line_control_register[1:0])
      2'd0:    mask = 8'h1F;
      2'd1:    mask = 8'h3F;
      2'd2:    mask = 8'h7F;
      default: mask = 8'hFF;
    endcase
    c       = rx_char & mask;
    special = s_r.enhanced_feature_register[EFR_SPEC] & (c == (s_r.xoff2 & mask));
    if (s_r.enhanced_feature_register[EFR_DBL])
    begin
      is_xoff = s_r.xoff1_seen & (c == (s_r.xoff2 & mask));
      is_xon  = s_r.xon1_seen & (c == (s_r.xon2 & mask));
    end
    else
    begin
      is_xoff = c == (s_r.xoff1 & mask);
      is_xon  = c == (s_r.xon1 & mask);
    end
    is_xoff = is_xoff & s_r.enhanced_feature_register[EFR_SWRX] & rx_valid & ~special;
    is_xon  = is_xon & s_r.enhanced_feature_register[EFR_SWRX] & rx_valid & ~special;
    if (rx_valid)
    begin
      s_nxt.xoff1_seen = s_r.enhanced_feature_register[EFR_DBL] & (c == (s_r.xoff1 & mask));
      s_nxt.xon1_seen  = s_r.enhanced_feature_register[EFR_DBL] & (c == (s_r.xon1 & mask));
    end
    // non-fifo mode keeps a single character
    push = rx_valid & ~is_xoff & ~is_xon
           & (s_r.fifo_control_register[FCR_EN] | (cnt == 8'h00));
    // -------------------------------------------------------------
    // bus slave: reads taken at address phase, writes at data phase
    // -------------------------------------------------------------
    acc = hsel & htrans[1] & hready;
    a   = haddr[7:0];
    case (a)
      A_RHR:   rd = head[7:0];
      A_IER:   rd = s_r.interrupt_enable_register;
      A_FCR:   rd = s_r.fifo_control_register;
      A_LCR:   rd = s_r.line_control_register;
      A_MCR:   rd = s_r.modem_control_register;
      A_LSR:   rd = {3'h0, head[10:8], 1'b0, cnt != 8'h00};
      A_ISR:   rd = {2'h0, s_r.interrupt_status_register, 4'h0};
      A_EFR:   rd = s_r.enhanced_feature_register;
      A_FEATURE_CONTROL_REGISTER:  rd = s_r.feature_control_register;
      A_XON1:  rd = s_r.xon1;
      A_XON2:  rd = s_r.xon2;
      A_XOFF1: rd = s_r.xoff1;
      A_XOFF2: rd = s_r.xoff2;
      A_TRIG:  rd = s_r.trig;
      A_HYST:  rd = s_r.hyst;
      A_FLVL:  rd = cnt;
      default: rd = 8'h00;
    endcase
    pop = acc & ~hwrite & (a == A_RHR);
    s_nxt.dph_wr = acc & hwrite;
    if (acc)
    begin
      s_nxt.dph_addr = a;
      s_nxt.rdata    = hwrite ? 32'h0000_0000 : {24'h00_0000, rd};
    end
    if (acc & ~hwrite & (a == A_ISR))
    begin
      s_nxt.interrupt_status_register = 2'b00;
    end
    if (s_r.dph_wr)
    begin
      case (s_r.dph_addr)
        A_IER:   s_nxt.interrupt_enable_register   = hwdata[7:0];
        A_FCR:   s_nxt.fifo_control_register   = hwdata[7:0];
        A_LCR:   s_nxt.line_control_register   = hwdata[7:0];
        A_MCR:   s_nxt.modem_control_register   = hwdata[7:0];
        A_EFR:   s_nxt.enhanced_feature_register   = hwdata[7:0];
        A_FEATURE_CONTROL_REGISTER:  s_nxt.feature_control_register  = hwdata[7:0];
        A_XON1:  s_nxt.xon1  = hwdata[7:0];
        A_XON2:  s_nxt.xon2  = hwdata[7:0];
        A_XOFF1: s_nxt.xoff1 = hwdata[7:0];
        A_XOFF2: s_nxt.xoff2 = hwdata[7:0];
        A_TRIG:  s_nxt.trig  = hwdata[7:0];
        A_HYST:  s_nxt.hyst  = hwdata[7:0];
        default: s_nxt.hyst  = s_nxt.hyst;
      endcase
    end
    // -------------------------------------------------------------
    // software flow: status sets placed after clears so sets win
    // -------------------------------------------------------------
    if (is_xon & s_r.sw_hold)
    begin
      s_nxt.sw_hold      = 1'b0;
      s_nxt.interrupt_status_register[ISR_XOFF] = 1'b0;
    end
    if (is_xoff)
    begin
      s_nxt.sw_hold = 1'b1;
      if (s_r.interrupt_enable_register[IER_XOFF])
      begin
        s_nxt.interrupt_status_register[ISR_XOFF] = 1'b1;
      end
    end
    if (special & rx_valid)
    begin
      s_nxt.interrupt_status_register[ISR_XOFF] = 1'b1;
    end
    // -------------------------------------------------------------
    // auto rts with hysteresis
    // -------------------------------------------------------------
    if (!s_r.enhanced_feature_register[EFR_ARTS])
    begin
      s_nxt.rts_off = 1'b0;
    end
    else if (cnt >= upper)
    begin
      s_nxt.rts_off = 1'b1;
    end
    else if (cnt <= lower)
    begin
      s_nxt.rts_off = 1'b0;
    end
    rts_now     = ~s_r.modem_control_register[MCR_RTS] | s_r.rts_off;
    s_nxt.rts_q = rts_now;
    s_nxt.cts_q = cts_n;
    if (rts_now & ~s_r.rts_q & s_r.interrupt_enable_register[IER_RTS] & s_r.enhanced_feature_register[EFR_ENH])
    begin
      s_nxt.interrupt_status_register[ISR_RTSCTS] = 1'b1;
    end
    if (cts_n & ~s_r.cts_q & s_r.interrupt_enable_register[IER_CTS] & s_r.enhanced_feature_register[EFR_ENH])
    begin
      s_nxt.interrupt_status_register[ISR_RTSCTS] = 1'b1;
    end
    // -------------------------------------------------------------
    // xoff/xon transmission requests
    // -------------------------------------------------------------
    bits        = 10'd7 + {8'h00, s_r.line_control_register[1:0]};
    s_nxt.above = cnt >= trig_lvl;
    if (s_r.enhanced_feature_register[EFR_XOFFTX] & s_nxt.above & ~s_r.above & ~s_r.xoff_sent
        & ~s_r.xt_on)
    begin
      s_nxt.xt_on = 1'b1;
      s_nxt.xt    = bits << CHAR_SHIFT;
    end
    else if (s_r.xt_on & tick16)
    begin
      s_nxt.xt = s_r.xt - 10'd1;
      if (s_r.xt <= 10'd1)
      begin
        s_nxt.xt_on     = 1'b0;
        s_nxt.send_xoff = 1'b1;
        s_nxt.xoff_sent = 1'b1;
      end
    end
    if (s_r.xoff_sent & (cnt <= lower))
    begin
      s_nxt.send_xon  = 1'b1;
      s_nxt.xoff_sent = 1'b0;
    end
    // -------------------------------------------------------------
    // infrared encoder and decoder
    // -------------------------------------------------------------
    if (tx_bit_start)
    begin
      s_nxt.tx_ph = 4'h0;
    end
    else if (tick16 & (s_r.tx_ph != TICK_LAST))
    begin
      s_nxt.tx_ph = s_r.tx_ph + 4'h1;
    end
    s_nxt.irtx = s_r.modem_control_register[MCR_IR] & ~tx_serial & (s_nxt.tx_ph < IR_PULSE);
    rin = rx_pin ^ s_r.feature_control_register[FEATURE_CONTROL_REGISTER_RXINV];
    if (rin)
    begin
      s_nxt.rx_str = TICK_LAST;
    end
    else if (tick16 & (s_r.rx_str != 4'h0))
    begin
      s_nxt.rx_str = s_r.rx_str - 4'h1;
    end
    // a pulse stretched to a bit reads as a zero; idle low reads as mark
    s_nxt.rxs = s_r.modem_control_register[MCR_IR] ? ~(rin | (s_r.rx_str != 4'h0)) : rx_pin;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r       <= '0;
      s_r.rts_q <= 1'b1;
      s_r.cts_q <= 1'b1;
      s_r.rxs   <= 1'b1;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.rdata;
  assign rts_n     = ~s_r.modem_control_register[MCR_RTS] | s_r.rts_off;
  // transmitter checks this only between characters
  assign tx_hold   = (s_r.enhanced_feature_register[EFR_ACTS] & cts_n) | s_r.sw_hold;
  assign send_xoff = s_r.send_xoff;
  assign send_xon  = s_r.send_xon;
  assign irq       = (|s_r.interrupt_status_register) | (s_r.interrupt_enable_register[IER_RXRDY] & s_r.above);
  assign irtx      = s_r.irtx;
  assign rx_serial = s_r.rxs;
endmodule : urx_flow

// ---- urx_flow_properties.sv ----
// checker: bus, flow pulse, freeze and infrared assertions
`timescale 1ns/100ps
module urx_flow_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rts_n,
  input wire logic        tx_hold,
  input wire logic        send_xoff,
  input wire logic        send_xon,
  input wire logic        irq,
  input wire logic        tx_serial,
  input wire logic        tick16,
  input wire logic        irtx,
  input wire logic        rx_serial
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // ticks seen inside one ir pulse
  // ----------------------------------------
  logic [4:0] ir_cnt_r;
  logic [4:0] ir_cnt_nxt;
  always_comb ir_cnt_nxt = irtx ? ir_cnt_r + 5'(tick16 && !tx_serial) : 5'h00;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) ir_cnt_r <= 5'h00;
    else ir_cnt_r <= ir_cnt_nxt;
  end
  sequence one_shot(s);
    s ##1 !s;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rdata_hold_a: assert property (!(hsel && htrans[1] && hready) |=> $stable(hrdata))
    else $error("read data moved without a transfer");
  reset_idle_a: assert property ($rose(hresetn) |->
    rts_n && !tx_hold && !irq && !irtx && rx_serial && !send_xoff && !send_xon)
    else $error("outputs not idle after reset");
  xoff_pulse_a: assert property (send_xoff |-> one_shot(send_xoff))
    else $error("xoff request longer than one cycle");
  xon_pulse_a: assert property (send_xon |-> one_shot(send_xon))
    else $error("xon request longer than one cycle");
  send_excl_a: assert property (!(send_xoff && send_xon))
    else $error("xon and xoff requested together");
  freeze_a: assert property (!ce |=> $stable({rts_n, tx_hold, irq, irtx, rx_serial}))
    else $error("state moved with clock enable low");
  ir_width_a: assert property (irtx |-> ir_cnt_r <= 5'h03)
    else $error("ir pulse wider than three ticks");
endmodule : urx_flow_chk
bind urx_flow urx_flow_chk chk_u (.hclk, .hresetn, .ce, .hsel, .htrans, .hready, .hreadyout,
  .hresp, .hrdata, .rts_n, .tx_hold, .send_xoff, .send_xon, .irq, .tx_serial, .tick16,
  .irtx, .rx_serial);

// ---- urx_pkg.sv ----
// package: register map, fields and constants of the receive flow block
package urx_pkg;
  localparam int          DEPTH      = 128;
  localparam int          AW         = 7;
  localparam int          EW         = 11;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  A_RHR      = 8'h00;
  localparam logic [7:0]  A_IER      = 8'h04;
  localparam logic [7:0]  A_FCR      = 8'h08;
  localparam logic [7:0]  A_LCR      = 8'h0C;
  localparam logic [7:0]  A_MCR      = 8'h10;
  localparam logic [7:0]  A_LSR      = 8'h14;
  localparam logic [7:0]  A_ISR      = 8'h18;
  localparam logic [7:0]  A_EFR      = 8'h1C;
  localparam logic [7:0]  A_FEATURE_CONTROL_REGISTER     = 8'h20;
  localparam logic [7:0]  A_XON1     = 8'h24;
  localparam logic [7:0]  A_XON2     = 8'h28;
  localparam logic [7:0]  A_XOFF1    = 8'h2C;
  localparam logic [7:0]  A_XOFF2    = 8'h30;
  localparam logic [7:0]  A_TRIG     = 8'h34;
  localparam logic [7:0]  A_HYST     = 8'h38;
  localparam logic [7:0]  A_FLVL     = 8'h3C;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          FCR_EN     = 0;
  localparam int          FCR_TABD   = 5;
  localparam int          EFR_DBL    = 0;
  localparam int          EFR_SWRX   = 1;
  localparam int          EFR_XOFFTX = 3;
  localparam int          EFR_ENH    = 4;
  localparam int          EFR_SPEC   = 5;
  localparam int          EFR_ARTS   = 6;
  localparam int          EFR_ACTS   = 7;
  localparam int          IER_RXRDY  = 0;
  localparam int          IER_XOFF   = 5;
  localparam int          IER_RTS    = 6;
  localparam int          IER_CTS    = 7;
  localparam int          ISR_XOFF   = 4;
  localparam int          ISR_RTSCTS = 5;
  localparam int          MCR_RTS    = 1;
  localparam int          MCR_IR     = 6;
  localparam int          FEATURE_CONTROL_REGISTER_RXINV = 2;
  // ---------------------------------------------------------------
  // reset values, timing and fifo levels
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_REG    = 8'h00;
  localparam logic [3:0]  IR_PULSE   = 4'h3;
  localparam logic [3:0]  TICK_LAST  = 4'hF;
  localparam int          CHAR_SHIFT = 5;
  localparam logic [7:0]  FULL_LVL   = 8'h80;
  localparam logic [7:0]  TRIG_B0    = 8'h08;
  localparam logic [7:0]  TRIG_B1    = 8'h10;
  localparam logic [7:0]  TRIG_B2    = 8'h18;
  localparam logic [7:0]  TRIG_B3    = 8'h1C;
endpackage : urx_pkg

// ---- urx_remote.sv ----
// remote side: tick source, character injector, transmitter and rx pin
`timescale 1ns/100ps
module urx_remote
(
  input  wire logic  hclk,
  input  wire logic  tx_hold,
  output logic       rx_valid,
  output logic [7:0] rx_char,
  output logic [2:0] rx_err,
  output logic       tick16,
  output logic       cts_n,
  output logic       tx_serial,
  output logic       tx_bit_start,
  output logic       rx_pin
);
  // ----------------------------------------
  // one frame: start, data 5a, stop
  // ----------------------------------------
  logic [3:0] sub = 4'h0;
  logic [3:0] bn  = 4'h9;
  logic [9:0] frm = 10'h2B4;
  initial
  begin
    {rx_valid, rx_char, rx_err, tick16, cts_n, tx_bit_start, rx_pin} = '0;
  end
  assign tx_serial = frm[bn];
  // hold only at the stop bit so a frame is never cut short
  always @(posedge hclk)
  begin
    tick16 <= !tick16;
    tx_bit_start <= 1'b0;
    if (tick16)
    begin
      sub <= sub + 4'h1;
      if (sub == 4'hF)
      begin
        bn <= (bn != 4'h9) ? bn + 4'h1 : (tx_hold ? bn : 4'h0);
        tx_bit_start <= !(bn == 4'h9 && tx_hold);
      end
    end
  end
  task automatic put(input logic [7:0] c, input logic [2:0] e);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_char <= c;
    rx_err <= e;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
    rx_err <= ~e;
  endtask : put
endmodule : urx_remote
